// >>> verilog/acp_defs.svh
// Purpose: constants of the ASCII command parser
// Assumes: included by the package; the design file relies on that include
// Notes: definitions only
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
// ============================================================
// Sizes
`define ACP_NSLOT 22
`define ACP_NPAR 4
// ============================================================
// Staging slots, in commit order
`define ACP_SLOT_FMT 5'h02
`define ACP_SLOT_INTV 5'h12
`define ACP_SLOT_LAST 5'h15
`define ACP_SLOT_NONE 5'h1F
// ============================================================
// Characters and limits
`define ACP_WS_MAX 8'h20
`define ACP_NUM_MAX 17'h0FFFF
`define ACP_REP_DONE 3'h5
`define ACP_REP_UNITS 3'h4
// ============================================================
// Error codes
`define ACP_ERR_NONE 4'h0
`define ACP_ERR_SYNTAX 4'h1
`define ACP_ERR_CONFLICT 4'h4
`endif

// >>> verilog/acp_pkg.sv
// Purpose: types of the ASCII command parser
// Assumes: acp_defs.svh on the include path
// Notes: identifier is {kind, letter index}
`include "acp_defs.svh"
package acp_pkg;
    // ========================================================
    // Identifier kinds
    typedef enum logic [1:0] {
        ACP_K_PLAIN = 2'h0,
        ACP_K_HASH = 2'h1,
        ACP_K_AT = 2'h2,
        ACP_K_STAR = 2'h3
    } acp_kind_e;
    // ========================================================
    // Parser states, one-hot
    typedef enum logic [6:0] {
        ACP_IDLE = 7'h01,
        ACP_STAR = 7'h02,
        ACP_IDENT = 7'h04,
        ACP_ARGS = 7'h08,
        ACP_SKIP = 7'h10,
        ACP_EXEC = 7'h20,
        ACP_REPLY = 7'h40
    } acp_state_e;
    typedef logic [`ACP_NPAR-1:0][15:0] acp_par_t;
endpackage : acp_pkg

// >>> verilog/acp_parser.sv
// Purpose: ASCII command interpreter with staged, committed settings
// Assumes: one 20 MHz clock; host paces replies without back-pressure
// Notes: one clock domain; the character FIFO stalls while committing or replying
// Function
// - Identifiers: letter, letter#, @, *letter
// - Letters are case-insensitive
// - Codes 32 and below are white space
// - White space ends a numeric option
// - Comma or white space separates parameters
// - Single or concatenated commands behave alike
// - Any number of commits per string
// - Immediate commands act when interpreted
// - Replies use five zero-padded digits; the error query replies E and one digit
// - Leading zeros on input are accepted
// - Conflicts raise error indicator and code
// - Too-short interval replaced by fastest possible
// - Commands processed in arrival order
// - Deferred commands staged, last occurrence wins
// - Commit applies staged settings in fixed order
// - Commit closes the command line
// - After error skip through next commit
// - Deferred settings applied all or none
// - Fixed immediate and deferred command sets
// - Some commands exist on one variant only
// - Digital output immediate, data format at commit

// ============================================================
// Character FIFO
module acp_fifo
    import acp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
    } acp_fifo_s;
    acp_fifo_s r, next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Handshakes; ready is registered so it never depends on the pop
    assign push = in_valid && r.not_full;
    assign pop = out_ready && (r.cnt != '0);
    assign in_ready = r.not_full;
    assign out_valid = (r.cnt != '0);
    assign out_data = mem[r.rp];

    // Pointer and count update
    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.wp = r.wp + 1'b1;
        end
        if (pop)
        begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_r.not_full = (next_r.cnt != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r <= '{wp: '0, rp: '0, cnt: '0, not_full: 1'b1};
        end
        else
        begin
            r <= next_r;
        end
        if (push)
        begin
            mem[r.wp] <= in_data;
        end
    end
endmodule : acp_fifo

// ============================================================
// Parser top
module acp_parser
    import acp_pkg::*;
#(
    parameter int FIFO_DEPTH = 32,
    parameter logic [15:0] MIN_INTV_PER_CHAN = 16'h0001
)(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command characters from host
    input wire logic [7:0] rx_char,
    input wire logic rx_valid,
    output logic rx_ready,
    // Configuration and status inputs
    input wire logic variant_pin,
    input wire logic [15:0] chan_count,
    input wire logic [15:0] status_word,
    // Immediate command strobe
    output logic imm_valid,
    output logic [6:0] imm_id,
    output logic imm_query,
    output acp_par_t imm_par,
    // Committed deferred setting strobe
    output logic def_valid,
    output logic [4:0] def_slot,
    output acp_par_t def_par,
    // Applied settings and status
    output logic [15:0] dout,
    output logic [15:0] data_fmt,
    output logic err_led,
    // Reply characters
    output logic reply_valid,
    output logic [7:0] reply_char
);
    typedef struct packed {
        acp_state_e st;
        acp_state_e ret;
        logic [1:0] vsync;
        logic cur_vld;
        logic [6:0] cur_id;
        logic cur_q;
        acp_par_t par;
        logic [2:0] pidx;
        logic in_num;
        logic [16:0] num;
        logic perr;
        logic [`ACP_NSLOT-1:0] pend;
        logic [`ACP_NSLOT-1:0][`ACP_NPAR-1:0][15:0] stage;
        logic [4:0] ex;
        logic [3:0] err;
        logic rep_pre;
        logic [15:0] rep_val;
        logic [2:0] rep_idx;
        logic [3:0] rep_cnt;
        logic imm_valid;
        logic [6:0] imm_id;
        logic imm_query;
        acp_par_t imm_par;
        logic def_valid;
        logic [4:0] def_slot;
        acp_par_t def_par;
        logic [15:0] dout;
        logic [15:0] fmt;
        logic err_led;
        logic reply_valid;
        logic [7:0] reply_char;
    } acp_parser_s;
    acp_parser_s r, next_r;

    logic [7:0] ch;
    logic ch_valid, take;

    // ========================================================
    // Decode functions
    // Commit slot of a deferred command, none for immediates
    function automatic logic [4:0] slot_of(input logic [6:0] id, input logic var_b);
        logic [4:0] s;
        s = `ACP_SLOT_NONE;
        case (id)
            {ACP_K_PLAIN, 5'h15}: s = 5'h00;
            {ACP_K_PLAIN, 5'h10}: s = 5'h01;
            {ACP_K_PLAIN, 5'h05}: s = 5'h02;
            {ACP_K_PLAIN, 5'h0C}: s = 5'h03;
            {ACP_K_PLAIN, 5'h0D}: s = 5'h04;
            {ACP_K_PLAIN, 5'h0B}: s = 5'h05;
            {ACP_K_PLAIN, 5'h00}: s = 5'h06;
            {ACP_K_HASH, 5'h00}: s = 5'h07;
            {ACP_K_HASH, 5'h08}: s = 5'h08;
            {ACP_K_STAR, 5'h02}: s = 5'h09;
            {ACP_K_PLAIN, 5'h02}: s = 5'h0A;
            {ACP_K_STAR, 5'h16}: s = var_b ? `ACP_SLOT_NONE : 5'h0B;
            {ACP_K_HASH, 5'h0B}: s = var_b ? `ACP_SLOT_NONE : 5'h0C;
            {ACP_K_HASH, 5'h03}: s = var_b ? 5'h0D : `ACP_SLOT_NONE;
            {ACP_K_HASH, 5'h05}: s = var_b ? 5'h0E : `ACP_SLOT_NONE;
            {ACP_K_HASH, 5'h0C}: s = var_b ? 5'h0F : `ACP_SLOT_NONE;
            {ACP_K_HASH, 5'h16}: s = var_b ? 5'h10 : `ACP_SLOT_NONE;
            {ACP_K_PLAIN, 5'h0F}: s = 5'h11;
            {ACP_K_PLAIN, 5'h08}: s = 5'h12;
            {ACP_K_PLAIN, 5'h18}: s = 5'h13;
            {ACP_K_PLAIN, 5'h13}: s = 5'h14;
            {ACP_K_AT, 5'h00}: s = 5'h15;
            default: s = `ACP_SLOT_NONE;
        endcase
        return s;
    endfunction : slot_of

    // Known immediate identifiers for the active variant
    function automatic logic is_imm(input logic [6:0] id, input logic var_b);
        logic ok;
        ok = 1'b0;
        case (id)
            {ACP_K_STAR, 5'h01}, {ACP_K_STAR, 5'h05}, {ACP_K_STAR, 5'h0A},
            {ACP_K_STAR, 5'h0F}, {ACP_K_STAR, 5'h11}, {ACP_K_STAR, 5'h12},
            {ACP_K_STAR, 5'h13}, {ACP_K_HASH, 5'h02}, {ACP_K_HASH, 5'h11},
            {ACP_K_PLAIN, 5'h04}, {ACP_K_PLAIN, 5'h06}, {ACP_K_PLAIN, 5'h07},
            {ACP_K_PLAIN, 5'h09}, {ACP_K_PLAIN, 5'h0A}, {ACP_K_PLAIN, 5'h0E},
            {ACP_K_PLAIN, 5'h11}, {ACP_K_PLAIN, 5'h12}, {ACP_K_PLAIN, 5'h14}:
                ok = 1'b1;
            {ACP_K_STAR, 5'h06}: ok = !var_b;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : is_imm

    function automatic logic [16:0] pow10(input logic [2:0] idx);
        logic [16:0] p;
        case (idx)
            3'h0: p = 17'h02710;
            3'h1: p = 17'h003E8;
            3'h2: p = 17'h00064;
            3'h3: p = 17'h0000A;
            default: p = 17'h00001;
        endcase
        return p;
    endfunction : pow10

    // ========================================================
    // Input buffer; stalls while committing or replying
    acp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_data(rx_char),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .out_data(ch),
        .out_valid(ch_valid),
        .out_ready(take)
    );

    assign take = ch_valid && (r.st != ACP_EXEC) && (r.st != ACP_REPLY);

    // ========================================================
    // Next-state logic
    always_comb
    begin
        logic [7:0] uc;
        logic is_ws, is_dig, is_let, is_start, do_disp, bad, var_b;
        logic [4:0] slot;
        logic [16:0] acc;
        logic [15:0] min_iv;
        acp_par_t cp;
        logic [2:0] cpi;
        logic cperr;
        uc = '0;
        is_ws = 1'b0;
        is_dig = 1'b0;
        is_let = 1'b0;
        is_start = 1'b0;
        do_disp = 1'b0;
        bad = 1'b0;
        var_b = r.vsync[1];
        slot = `ACP_SLOT_NONE;
        acc = '0;
        min_iv = '0;
        next_r = r;
        next_r.imm_valid = 1'b0;
        next_r.def_valid = 1'b0;
        next_r.reply_valid = 1'b0;
        next_r.vsync = {r.vsync[0], variant_pin};
        next_r.err_led = (r.err != `ACP_ERR_NONE);
        // Close any open option before use
        cp = r.par;
        cpi = r.pidx;
        cperr = r.perr;
        if (r.in_num)
        begin
            if (r.pidx < 3'(`ACP_NPAR))
            begin
                cp[r.pidx[1:0]] = r.num[15:0];
            end
            else
            begin
                cperr = 1'b1;
            end
            cpi = r.pidx + 3'h1;
        end
        uc = ((ch >= 8'h61) && (ch <= 8'h7A)) ? (ch - 8'h20) : ch;
        is_ws = (ch <= `ACP_WS_MAX);
        is_dig = (ch >= 8'h30) && (ch <= 8'h39);
        is_let = (uc >= 8'h41) && (uc <= 8'h5A);
        is_start = is_let || (ch == 8'h2A) || (ch == 8'h40);
        do_disp = take && r.cur_vld && is_start && (r.st != ACP_SKIP) && (r.st != ACP_STAR);
        slot = slot_of(r.cur_id, var_b);
        min_iv = 16'(chan_count * MIN_INTV_PER_CHAN);
        case (r.st)
            ACP_IDLE, ACP_IDENT, ACP_ARGS:
            begin
                if (take)
                begin
                    if (is_ws || (ch == 8'h2C))
                    begin
                        next_r.par = cp;
                        next_r.pidx = cpi;
                        next_r.perr = cperr;
                        next_r.in_num = 1'b0;
                        if (r.st == ACP_IDENT)
                        begin
                            next_r.st = ACP_ARGS;
                        end
                    end
                    else if (is_dig && r.cur_vld)
                    begin
                        acc = r.in_num ? (r.num * 17'h0000A) : '0;
                        acc = acc + {13'h0000, ch[3:0]};
                        next_r.num = acc;
                        next_r.perr = r.perr || (acc > `ACP_NUM_MAX);
                        next_r.in_num = 1'b1;
                        next_r.st = ACP_ARGS;
                    end
                    else if ((ch == 8'h23) && (r.st == ACP_IDENT)
                        && (r.cur_id[6:5] == ACP_K_PLAIN))
                    begin
                        next_r.cur_id[6:5] = ACP_K_HASH;
                    end
                    else if ((ch == 8'h3F) && r.cur_vld && !r.in_num)
                    begin
                        next_r.cur_q = 1'b1;
                    end
                    else if (is_start)
                    begin
                        next_r.cur_vld = 1'b0;
                        next_r.cur_q = 1'b0;
                        next_r.par = '0;
                        next_r.pidx = '0;
                        next_r.in_num = 1'b0;
                        next_r.perr = 1'b0;
                        if (ch == 8'h2A)
                        begin
                            next_r.st = ACP_STAR;
                        end
                        else if (uc == 8'h58)
                        begin
                            next_r.st = ACP_EXEC;
                            next_r.ex = '0;
                        end
                        else
                        begin
                            next_r.cur_vld = 1'b1;
                            next_r.cur_id = (ch == 8'h40) ? {ACP_K_AT, 5'h00}
                                : {ACP_K_PLAIN, 5'(uc - 8'h41)};
                            next_r.st = ACP_IDENT;
                        end
                    end
                    else
                    begin
                        bad = 1'b1;
                    end
                end
            end
            ACP_STAR:
            begin
                if (take)
                begin
                    if (is_let)
                    begin
                        next_r.cur_vld = 1'b1;
                        next_r.cur_id = {ACP_K_STAR, 5'(uc - 8'h41)};
                        next_r.st = ACP_IDENT;
                    end
                    else
                    begin
                        bad = 1'b1;
                    end
                end
            end
            ACP_SKIP:
            begin
                // Discard everything up to and including the commit
                if (take && (uc == 8'h58))
                begin
                    next_r.pend = '0;
                    next_r.st = ACP_IDLE;
                end
            end
            ACP_EXEC:
            begin
                // Walk slots in commit order, one per cycle
                if (r.pend[r.ex])
                begin
                    next_r.def_valid = 1'b1;
                    next_r.def_slot = r.ex;
                    next_r.def_par = r.stage[r.ex];
                    if (r.ex == `ACP_SLOT_FMT)
                    begin
                        next_r.fmt = r.stage[r.ex][0];
                    end
                end
                next_r.ex = r.ex + 5'h01;
                if (r.ex == `ACP_SLOT_LAST)
                begin
                    next_r.pend = '0;
                    next_r.st = ACP_IDLE;
                end
            end
            ACP_REPLY:
            begin
                // Fixed-width decimal by repeated subtraction
                if (r.rep_pre)
                begin
                    next_r.reply_valid = 1'b1;
                    next_r.reply_char = 8'h45;
                    next_r.rep_pre = 1'b0;
                end
                else if (r.rep_idx == `ACP_REP_DONE)
                begin
                    next_r.st = r.ret;
                end
                else if ({1'b0, r.rep_val} >= pow10(r.rep_idx))
                begin
                    next_r.rep_val = 16'({1'b0, r.rep_val} - pow10(r.rep_idx));
                    next_r.rep_cnt = r.rep_cnt + 4'h1;
                end
                else
                begin
                    next_r.reply_valid = 1'b1;
                    next_r.reply_char = {4'h3, r.rep_cnt};
                    next_r.rep_cnt = '0;
                    next_r.rep_idx = r.rep_idx + 3'h1;
                end
            end
            default:
            begin
                next_r.st = ACP_IDLE;
            end
        endcase
        // Finish the previous command when a new token starts
        if (do_disp)
        begin
            if (cperr)
            begin
                bad = 1'b1;
                next_r.err = `ACP_ERR_CONFLICT;
            end
            else if (is_imm(r.cur_id, var_b) || (r.cur_q && slot != `ACP_SLOT_NONE))
            begin
                next_r.imm_valid = 1'b1;
                next_r.imm_id = r.cur_id;
                next_r.imm_query = r.cur_q;
                next_r.imm_par = cp;
                if (r.cur_id == {ACP_K_PLAIN, 5'h0E})
                begin
                    next_r.dout = cp[0];
                end
                if (r.cur_q || (r.cur_id == {ACP_K_PLAIN, 5'h14}))
                begin
                    next_r.ret = next_r.st;
                    next_r.st = ACP_REPLY;
                    next_r.rep_pre = 1'b0;
                    next_r.rep_idx = '0;
                    next_r.rep_cnt = '0;
                    next_r.rep_val = status_word;
                    if (r.cur_id == {ACP_K_PLAIN, 5'h04})
                    begin
                        next_r.rep_pre = 1'b1;
                        next_r.rep_idx = `ACP_REP_UNITS;
                        next_r.rep_val = {12'h000, r.err};
                        next_r.err = `ACP_ERR_NONE;
                    end
                    else if (slot != `ACP_SLOT_NONE)
                    begin
                        next_r.rep_val = r.stage[slot][0];
                    end
                end
            end
            else if (slot != `ACP_SLOT_NONE)
            begin
                next_r.pend[slot] = 1'b1;
                next_r.stage[slot] = cp;
                if ((slot == `ACP_SLOT_INTV) && (cp[0] < min_iv))
                begin
                    next_r.stage[slot][0] = min_iv;
                    next_r.err = `ACP_ERR_CONFLICT;
                end
            end
            else
            begin
                bad = 1'b1;
                next_r.err = `ACP_ERR_SYNTAX;
            end
        end
        // Error drops the line; a commit in the same cycle closes it
        if (bad)
        begin
            next_r.cur_vld = 1'b0;
            next_r.in_num = 1'b0;
            if (take && (uc == 8'h58))
            begin
                next_r.pend = '0;
                next_r.st = ACP_IDLE;
            end
            else
            begin
                next_r.st = ACP_SKIP;
            end
            if (next_r.err == `ACP_ERR_NONE)
            begin
                next_r.err = `ACP_ERR_SYNTAX;
            end
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            r <= '0;
            r.st <= ACP_IDLE;
            r.ret <= ACP_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign imm_valid = r.imm_valid;
    assign imm_id = r.imm_id;
    assign imm_query = r.imm_query;
    assign imm_par = r.imm_par;
    assign def_valid = r.def_valid;
    assign def_slot = r.def_slot;
    assign def_par = r.def_par;
    assign dout = r.dout;
    assign data_fmt = r.fmt;
    assign err_led = r.err_led;
    assign reply_valid = r.reply_valid;
    assign reply_char = r.reply_char;
endmodule : acp_parser

// >>> verif/acp_host.sv
// Purpose: host model feeding command strings
// Assumes: caller enters send just after a rising edge
// Notes: idle data line carries the inverse of the last char
module acp_host
(
    // Clock
    input wire logic clk,
    // Character bus
    output logic [7:0] rx_char,
    output logic rx_valid,
    input wire logic rx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================
    // Idle at time zero
    initial
    begin
        rx_char = 8'h00;
        rx_valid = 1'b0;
    end
    // Each char held until taken; no white space inside a number
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            #1 rx_valid = 1'b1;
            rx_char = s[i];
            do @(posedge clk); while (rx_ready !== 1'b1);
        end
        #1 rx_valid = 1'b0;
        rx_char = ~rx_char;
    endtask : send
endmodule : acp_host

// >>> verif/acp_parser_chk.sv
// Purpose: port checker of the command parser
// Assumes: single clock, synchronous reset
// Notes: bound to every parser instance
module acp_parser_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic imm_valid,
    input wire logic [6:0] imm_id,
    input wire logic def_valid,
    input wire logic [4:0] def_slot,
    input wire logic [15:0] dout,
    input wire logic [15:0] data_fmt,
    input wire logic err_led,
    input wire logic reply_valid,
    input wire logic [7:0] reply_char
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic o_hit;
    logic f_hit;
    // ========================================================
    // Last cycle's strobes, so a one-cycle output lag passes
    always_ff @(posedge clk)
    begin
        o_hit <= imm_valid && imm_id == 7'h0E;
        f_hit <= def_valid && def_slot == 5'h02;
    end
    property p_dout_src;
        !$stable(dout) |-> (imm_valid && imm_id == 7'h0E) || o_hit;
    endproperty
    a_dout_src: assert property (p_dout_src)
        else $error("digital output moved without its command");
    property p_fmt_src;
        !$stable(data_fmt) |-> (def_valid && def_slot == 5'h02) || f_hit;
    endproperty
    a_fmt_src: assert property (p_fmt_src)
        else $error("data format moved outside commit");
    property p_slot_seq;
        def_valid ##1 def_valid |-> def_slot == $past(def_slot) + 5'h01;
    endproperty
    a_slot_seq: assert property (p_slot_seq)
        else $error("commit slots out of order");
    property p_slot_max;
        def_valid |-> def_slot <= 5'h15;
    endproperty
    a_slot_max: assert property (p_slot_max)
        else $error("commit slot beyond last");
    property p_full_cause;
        $fell(rx_ready) |-> $past(rx_valid);
    endproperty
    a_full_cause: assert property (p_full_cause)
        else $error("ready fell without a char offered");
    property p_reply_set;
        reply_valid |-> (reply_char >= 8'h30 && reply_char <= 8'h39) || reply_char == 8'h45;
    endproperty
    a_reply_set: assert property (p_reply_set)
        else $error("reply char not a digit or error tag");
    property p_id_range;
        imm_valid |-> imm_id[4:0] <= 5'h19;
    endproperty
    a_id_range: assert property (p_id_range)
        else $error("identifier letter out of range");
    property p_err_clear;
        reply_valid && reply_char == 8'h45 |-> ##[1:16] !err_led;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error indicator not cleared by query");
    c_commit: cover property (def_valid);
    c_reply: cover property (reply_valid);
    c_err: cover property ($rose(err_led));
    c_full: cover property ($fell(rx_ready));
endmodule : acp_parser_chk
bind acp_parser acp_parser_chk u_chk (.clk, .reset, .rx_valid, .rx_ready, .imm_valid,
    .imm_id, .def_valid, .def_slot, .dout, .data_fmt, .err_led, .reply_valid, .reply_char);

// >>> verif/acp_parser_tb_top.sv
// Purpose: self-checking bench of the command parser
// Assumes: host model on the char bus, variant A, then B
// Notes: expected state kept in ints, logs in strings
module acp_parser_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] rx_char;
    logic rx_valid;
    logic rx_ready;
    logic [15:0] status_word = 16'h0000;
    logic [15:0] chan_count = 16'h0003;
    logic variant_pin = 1'b0;
    logic [15:0] dout;
    logic [15:0] data_fmt;
    logic err_led;
    logic def_valid;
    logic [4:0] def_slot;
    acp_pkg::acp_par_t def_par;
    logic reply_valid;
    logic [7:0] reply_char;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'hc2d3;
    int cycles = 0;
    int ed = 0;
    int ef = 0;
    int v;
    bit el = 1'b0;
    bit saw_full = 1'b0;
    string rlog = "";
    string dlog = "";
    always #25 clk = ~clk;
    acp_host host (.clk, .rx_char, .rx_valid, .rx_ready);
    acp_parser dut (.clk, .reset, .rx_char, .rx_valid, .rx_ready, .variant_pin,
        .chan_count, .status_word, .imm_valid(), .imm_id(), .imm_query(),
        .imm_par(), .def_valid, .def_slot, .def_par, .dout, .data_fmt, .err_led,
        .reply_valid, .reply_char);
    // ========================================================
    // Log one-cycle outputs; cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (reply_valid === 1'b1)
            rlog = {rlog, $sformatf("%c", reply_char)};
        if (def_valid === 1'b1)
            dlog = {dlog, $sformatf("%0d:%0d ", def_slot, def_par[0])};
        if (rx_ready === 1'b0 && rx_valid === 1'b1)
            saw_full = 1'b1;
        if (cycles == 6000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input string got, input string exp);
        compares++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: got %s expected %s", $time, got, exp);
        end
    endtask : chk
    // Compare the standing outputs with the model
    task automatic st();
        chk($sformatf("%h %h %b", dout, data_fmt, err_led),
            $sformatf("%h %h %b", ed[15:0], ef[15:0], el));
    endtask : st
    // Commit walk and replies settle well inside the idle time
    task automatic run(input string s);
        rlog = "";
        dlog = "";
        @(posedge clk);
        host.send(s);
        repeat (120) @(posedge clk);
        #1;
    endtask : run
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // ========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        st();
        $display("test reset done");
        run("o5\tF1,1 f 00003");
        ed = 5;
        st();
        run("x");
        ef = 3;
        st();
        chk(dlog, "2:3 ");
        $display("test staging done");
        run("F6 V1 Q2X");
        ef = 6;
        st();
        chk(dlog, "0:1 1:2 2:6 ");
        $display("test order done");
        run("o7 zz O9 F9X");
        ed = 7;
        el = 1'b1;
        st();
        chk(dlog, "");
        run("E?X");
        el = 1'b0;
        chk(rlog, "E1");
        st();
        run("F70000X");
        el = 1'b1;
        st();
        run("I2X");
        chk(dlog, "18:3 ");
        run("e?x");
        el = 1'b0;
        chk(rlog, "E4");
        $display("test errors done");
        repeat (3)
        begin
            @(posedge clk);
            #1 status_word = $random(seed);
            v = {$random(seed)} % 65536;
            run($sformatf("o%05d u x m1x", v));
            ed = v;
            chk(rlog, $sformatf("%05d", status_word));
            chk(dlog, "3:1 ");
            st();
        end
        $display("test random done");
        run({"xx", {40{string'(" ")}}});
        chk($sformatf("%b", saw_full), "1");
        st();
        $display("test fill done");
        variant_pin = 1'b1;
        run("D#5X");
        chk(dlog, "13:5 ");
        $display("test variant done");
        conclude();
    end
endmodule : acp_parser_tb_top
